/* hdl/per_channel_select_regs.sv */
`timescale 1ns/1ps
module per_channel_select_regs (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host parallel port
   input wire chan_sel_pkg::host_req_t host_req,
   output chan_sel_pkg::host_rsp_t host_rsp,
   // channel maps to the per-channel functions
   output chan_sel_pkg::chan_sel_t chan_sel,
   // current pointer, for visibility
   output logic [chan_sel_pkg::DATA_W-1:0] func_pointer
);
   import chan_sel_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] pointer;
      logic [DATA_W-1:0] rdata;
      logic rvalid;
   } regs_t;

   regs_t state_q;
   regs_t state_d;

   logic [NUM_FUNC-1:0][NUM_CH-1:0] maps;
   logic [NUM_BYTES-1:0] byte_we;
   logic [NUM_BYTES-1:0] byte_hit;

   // which map byte an address names, one-hot, zero when none
   function automatic logic [NUM_BYTES-1:0] map_byte(
      input logic [ADDR_W-1:0] addr
   );
      logic [NUM_BYTES-1:0] hit;
      hit = '0;
      unique case (addr)
         OFS_MAP_1_8: hit = 4'h1;
         OFS_MAP_9_16: hit = 4'h2;
         OFS_MAP_17_24: hit = 4'h4;
         OFS_MAP_25_32: hit = 4'h8;
         default: hit = 4'h0;
      endcase
      return hit;
   endfunction

   // lowest selected function, the one a map read shows
   function automatic logic [2:0] first_sel(
      input logic [NUM_FUNC-1:0] ptr
   );
      logic [2:0] idx;
      idx = 3'h0;
      for (int f = NUM_FUNC - 1; f >= 0; f--) begin
         if (ptr[f]) begin
            idx = f[2:0];
         end
      end
      return idx;
   endfunction

   assign byte_hit = map_byte(host_req.addr);

   // map writes use the pointer as it stands at that edge
   assign byte_we = host_req.wr ? byte_hit : '0;

   // one store per function; every set pointer bit enables its store
   generate
      for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
         chan_map_store u_store (
            .clk(clk),
            .rst_n(rst_n),
            .sel(state_q.pointer[f]),
            .byte_we(byte_we),
            .wdata(host_req.wdata),
            .map(maps[f])
         );
      end
   endgenerate

   // pointer write and registered read data
   always_comb begin
      logic [DATA_W-1:0] rd_val;
      logic [2:0] fsel;
      rd_val = UNMAPPED_READ;
      fsel = first_sel(state_q.pointer);
      state_d = state_q;
      state_d.rvalid = 1'b0;
      if (host_req.wr && host_req.addr == OFS_POINTER) begin
         state_d.pointer = host_req.wdata;
      end
      // read returns pre-write contents when both strobes coincide
      if (host_req.addr == OFS_POINTER) begin
         rd_val = state_q.pointer;
      end else begin
         for (int b = 0; b < NUM_BYTES; b++) begin
            if (byte_hit[b] && state_q.pointer != '0) begin
               rd_val = maps[fsel][b*DATA_W +: DATA_W];
            end
         end
      end
      if (host_req.rd) begin
         state_d.rdata = rd_val;
         state_d.rvalid = 1'b1;
      end
   end

   // pointer and read path cleared on reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q.pointer <= POINTER_RESET;
         state_q.rdata <= RDATA_RESET;
         state_q.rvalid <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign host_rsp.rvalid = state_q.rvalid;
   assign host_rsp.rdata = state_q.rdata;
   assign func_pointer = state_q.pointer;

   // function outputs by pointer bit position
   // bit-error test and fractional maps
   assign chan_sel.tx_biterr_test_sel = maps[FN_TX_BERT];
   assign chan_sel.rx_biterr_test_sel = maps[FN_RX_BERT];
   assign chan_sel.tx_fractional_sel = maps[FN_TX_FRAC];
   assign chan_sel.rx_fractional_sel = maps[FN_RX_FRAC];
   // payload error, tx hardware signaling and rx signaling maps
   assign chan_sel.payload_error_insert_sel = maps[FN_PAYLOAD_ERR];
   assign chan_sel.tx_hw_signaling_sel = maps[FN_TX_HW_SIG];
   assign chan_sel.rx_signaling_reinsert_sel = maps[FN_RX_SIG_REINS];
   assign chan_sel.rx_signaling_all_ones_sel = maps[FN_RX_ALL_ONES];
endmodule

/* include/chan_sel_pkg.sv */
package chan_sel_pkg;

   // bus and map geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_FUNC = 8;
   localparam int NUM_BYTES = 4;
   localparam int NUM_CH = 32;

   // register offsets on the parallel port
   localparam logic [7:0] OFS_POINTER = 8'h28;
   localparam logic [7:0] OFS_MAP_1_8 = 8'h29;
   localparam logic [7:0] OFS_MAP_9_16 = 8'h2a;
   localparam logic [7:0] OFS_MAP_17_24 = 8'h2b;
   localparam logic [7:0] OFS_MAP_25_32 = 8'h2c;

   // values after reset, and the read value when nothing is mapped
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [31:0] MAP_RESET = 32'h0000_0000;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // function bit positions in the pointer register
   localparam int FN_TX_BERT = 0;
   localparam int FN_TX_FRAC = 1;
   localparam int FN_PAYLOAD_ERR = 2;
   localparam int FN_TX_HW_SIG = 3;
   localparam int FN_RX_BERT = 4;
   localparam int FN_RX_FRAC = 5;
   localparam int FN_RX_SIG_REINS = 6;
   localparam int FN_RX_ALL_ONES = 7;

   // host request on the parallel port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_t;

   // host answer
   typedef struct packed {
      logic rvalid;
      logic [7:0] rdata;
   } host_rsp_t;

   // channel maps, highest pointer bit first so it overlays the array
   typedef struct packed {
      logic [31:0] rx_signaling_all_ones_sel;
      logic [31:0] rx_signaling_reinsert_sel;
      logic [31:0] rx_fractional_sel;
      logic [31:0] rx_biterr_test_sel;
      logic [31:0] tx_hw_signaling_sel;
      logic [31:0] payload_error_insert_sel;
      logic [31:0] tx_fractional_sel;
      logic [31:0] tx_biterr_test_sel;
   } chan_sel_t;

endpackage

/* hdl/chan_map_store.sv */
`timescale 1ns/1ps
module chan_map_store (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write side
   input wire logic sel,
   input wire logic [chan_sel_pkg::NUM_BYTES-1:0] byte_we,
   input wire logic [chan_sel_pkg::DATA_W-1:0] wdata,
   // stored map
   output logic [chan_sel_pkg::NUM_CH-1:0] map
);
   import chan_sel_pkg::*;

   typedef struct packed {
      logic [NUM_CH-1:0] map;
   } store_t;

   store_t state_q;
   store_t state_d;

   // byte lane update, only while this function is pointed at
   always_comb begin
      state_d = state_q;
      for (int b = 0; b < NUM_BYTES; b++) begin
         if (sel && byte_we[b]) begin
            state_d.map[b*DATA_W +: DATA_W] = wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q.map <= MAP_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign map = state_q.map;
endmodule

/* verification/chan_sel_checker.sv */
`timescale 1ns/1ps
module chan_sel_checker import chan_sel_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // watched ports
   input wire host_req_t host_req,
   input wire host_rsp_t host_rsp,
   input wire chan_sel_t chan_sel,
   input wire logic [7:0] func_pointer
);
   // helper strobes for map writes
   wire w29 = host_req.wr && host_req.addr == 8'h29;
   wire w2a = host_req.wr && host_req.addr == 8'h2a;
   wire w2b = host_req.wr && host_req.addr == 8'h2b;
   wire w2c = host_req.wr && host_req.addr == 8'h2c;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ptr_load: assert property (
      host_req.wr && host_req.addr == 8'h28 |=>
      func_pointer == $past(host_req.wdata)) else $error("pointer bad");
   a_tx_bert: assert property (w29 && func_pointer[0] |=>
      chan_sel.tx_biterr_test_sel[7:0] == $past(host_req.wdata))
      else $error("tx bert map bad");
   a_rx_bert: assert property (w2a && func_pointer[4] |=>
      chan_sel.rx_biterr_test_sel[15:8] == $past(host_req.wdata))
      else $error("rx bert map bad");
   a_tx_frac: assert property (w2b && func_pointer[1] |=>
      chan_sel.tx_fractional_sel[23:16] == $past(host_req.wdata))
      else $error("tx frac map bad");
   a_rx_frac: assert property (w2c && func_pointer[5] |=>
      chan_sel.rx_fractional_sel[31:24] == $past(host_req.wdata))
      else $error("rx frac map bad");
   a_err_map: assert property (w29 && func_pointer[2] |=>
      chan_sel.payload_error_insert_sel[7:0] == $past(host_req.wdata))
      else $error("payload map bad");
   a_reins_keep: assert property (!func_pointer[6] |=>
      $stable(chan_sel.rx_signaling_reinsert_sel))
      else $error("reinsert map moved");
   a_read_ack: assert property (host_req.rd |=> host_rsp.rvalid)
      else $error("no read answer");
   // reset holds the channel maps and the pointer clear, checked while reset is low
   // own disable, else the default one would mask the whole antecedent
   a_reset_clr: assert property (@(posedge clk) disable iff (1'b0)
      !rst_n |-> chan_sel == '0 && func_pointer == 8'h00)
      else $error("reset bad");
endmodule
bind per_channel_select_regs chan_sel_checker u_chan_sel_checker (.*);

/* verification/host_model.sv */
`timescale 1ns/1ps
module host_model import chan_sel_pkg::*; (
   // port side
   input wire logic clk,
   output host_req_t req
);
   initial req = '0;
   // released bus shows inverted lines, not the stale value
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= {2'b10, a, d};
      @(posedge clk);
      req <= {2'b00, ~a, ~d};
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk);
      req <= {2'b01, a, 8'h00};
      @(posedge clk);
      req <= {2'b00, ~a, 8'hff};
   endtask
endmodule

/* verification/test_per_channel_select_regs.sv */
`timescale 1ns/1ps
module test_per_channel_select_regs import chan_sel_pkg::*;;
   logic clk = 0, rst_n = 1;
   host_req_t req;
   host_rsp_t rsp;
   chan_sel_t cs;
   logic [7:0] fp, p;
   logic [7:0][31:0] em;
   logic [7:0] q[$];
   int error_cnt = 0, n_tests = 0, cyc = 0;
   always #2 clk = ~clk;
   host_model u_host_model (.clk(clk), .req(req));
   per_channel_select_regs u_per_channel_select_regs (.clk(clk),
      .rst_n(rst_n), .host_req(req), .host_rsp(rsp), .chan_sel(cs),
      .func_pointer(fp));
   task chk(input logic [255:0] g, input logic [255:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task end_sim;
      if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // map writes land in every function whose pointer bit is set
   task mw(input logic [7:0] a, input logic [7:0] d);
      u_host_model.wr(a, d);
      if (a == 8'h28) p = d;
      else if (a >= 8'h29 && a <= 8'h2c)
         for (int f = 0; f < 8; f++)
            if (p[f]) em[f][8*(a-8'h29)+:8] = d;
   endtask
   // lowest selected function answers a map read
   task rdx(input logic [7:0] a);
      logic [7:0] e;
      e = 8'h00;
      if (a == 8'h28) e = p;
      else if (a >= 8'h29 && a <= 8'h2c)
         for (int f = 7; f >= 0; f--)
            if (p[f]) e = em[f][8*(a-8'h29)+:8];
      q.push_back(e);
      u_host_model.rd(a);
   endtask
   // read answers taken oldest first; also the hang guard
   always @(posedge clk) begin
      cyc++;
      if (rsp.rvalid === 1'b1) chk(rsp.rdata, q.pop_front());
      if (cyc == 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      // falling edge at time zero so the async reset acts before any clock
      rst_n <= 1'b0;
      void'($urandom(40598));
      em = '0;
      p = 8'h00;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(cs, em);
      for (int a = 8'h28; a <= 8'h2c; a++) rdx(8'(a));
      for (int i = 0; i < 8; i++) begin
         mw(8'h28, 8'(1 << i));
         for (int b = 0; b < 4; b++) mw(8'(8'h29 + b), 8'($urandom));
         @(posedge clk);
         chk(cs, em);
         rdx(8'(8'h29 + i % 4));
      end
      repeat (6) begin
         mw(8'h28, 8'($urandom));
         for (int b = 0; b < 4; b++) mw(8'(8'h29 + b), 8'($urandom));
         @(posedge clk);
         chk(cs, em);
         rdx(8'h28);
      end
      mw(8'h2d, 8'hff);
      mw(8'h28, 8'h00);
      mw(8'h2b, 8'hff);
      rdx(8'h30);
      @(posedge clk);
      chk(cs, em);
      repeat (3) @(posedge clk);
      end_sim();
   end
endmodule
